//--- fefp_defines.svh
// Offsets, field positions, symbol codes and counts for the frame path
// ----------------------------------------------------------------------
// Summary of operation
// - Copy commanded packet from host into transmit FIFO
// - Transmit starts on whole packet or threshold
// - Receive FIFO at threshold requests host transfer
// - Hash-filter multicast destinations while receiving
// - Internal loopback returns transmit frames to receiver
// - Internal loopback isolates the cable both ways
// - External loopback sends frames to line interface
// - Encode 4B/5B, JK replaces first preamble byte
// - Append TR pair after last FCS byte
// - Half duplex, no loopback: non-idle receive while sending collides
// - Collision in preamble: finish preamble, then jam
// - Receiver watches line, starts only on J symbol
// - Receiver expects JK as first preamble byte
// - Bad FCS or missing TR sets CRC error
// - Invalid mid-frame symbol sets CRC and symbol flags
// ----------------------------------------------------------------------
`ifndef FEFP_DEFINES_SVH
`define FEFP_DEFINES_SVH
`define FEFP_CTRL 12'h000
`define FEFP_TXADDR 12'h004
`define FEFP_TXLEN 12'h008
`define FEFP_RXSTAT 12'h00c
`define FEFP_HASH0 12'h010
`define FEFP_HASH1 12'h014
`define FEFP_ISTAT 12'h018
`define FEFP_IMASK 12'h01c
`define FEFP_STATE 12'h020
`define FEFP_CTRL_GO 4
`define FEFP_EV_W 6
`define FEFP_EV_TXDONE 0
`define FEFP_EV_COL 1
`define FEFP_EV_TXERR 2
`define FEFP_EV_RXDONE 3
`define FEFP_EV_RXERR 4
`define FEFP_EV_RXOVF 5
`define FEFP_SYM_I 5'h1f
`define FEFP_SYM_J 5'h18
`define FEFP_SYM_K 5'h11
`define FEFP_SYM_T 5'h0d
`define FEFP_SYM_R 5'h07
`define FEFP_PRE_LAST 4'hd
`define FEFP_JAM_LAST 4'h7
`define FEFP_NIB_PRE 4'h5
`define FEFP_NIB_SFD 4'hd
`define FEFP_CRC_INIT 32'hffffffff
`define FEFP_CRC_POLY 32'hedb88320
`define FEFP_CRC_RES 32'hdebb20e3
`endif

//--- fefp_pkg.sv
// Types shared by the frame path
package fefp_pkg;
  typedef enum logic [8:0] {
    TX_IDLE = 9'h001, TX_WAIT = 9'h002, TX_J = 9'h004, TX_K = 9'h008,
    TX_PRE = 9'h010, TX_DATA = 9'h020, TX_T = 9'h040, TX_R = 9'h080,
    TX_JAM = 9'h100
  } fefp_tx_st_t;
  typedef enum logic [5:0] {
    RX_IDLE = 6'h01, RX_K = 6'h02, RX_PRE = 6'h04, RX_DATA = 6'h08,
    RX_R = 6'h10, RX_DRAIN = 6'h20
  } fefp_rx_st_t;
  typedef struct packed {
    logic ext_loop;
    logic int_loop;
    logic full_dup;
    logic rx_en;
  } fefp_ctrl_t;
  typedef struct packed {
    logic [11:0] len;
    logic mc_rej;
    logic invalid_symbol_flag;
    logic crc_err;
    logic ok;
  } fefp_rxstat_t;
endpackage : fefp_pkg

//--- fefp_frame_path.sv
// Frame path: DMA staging FIFOs, 4B/5B framing, loopback, hash filter
`timescale 1ns/10ps
`include "fefp_defines.svh"
module fefp_frame_path
  import fefp_pkg::*;
#(
  parameter int AW = 11,
  parameter int LW = 11
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Configuration thresholds
  input wire logic [AW:0] tx_thresh,
  input wire logic [AW:0] rx_thresh,
  // Host memory read for transmit
  output logic txm_req,
  output logic [31:0] txm_addr,
  input wire logic txm_ack,
  input wire logic [7:0] txm_data,
  // Host memory write for receive
  output logic rxm_req,
  output logic [7:0] rxm_data,
  input wire logic rxm_ack,
  // Line symbols
  output logic [4:0] line_tx_sym,
  output logic line_tx_en,
  input wire logic [4:0] line_rx_sym
);

  typedef struct packed {
    fefp_ctrl_t ctrl;
    logic [31:0] tx_addr;
    logic [LW-1:0] tx_len;
    logic [63:0] hash;
    logic [`FEFP_EV_W-1:0] ist;
    logic [`FEFP_EV_W-1:0] imask;
    logic [31:0] prdata;
    logic pslverr;
    logic ld_act;
    logic ld_done;
    logic [31:0] ld_addr;
    logic [LW-1:0] ld_cnt;
    logic [AW:0] twp;
    logic [AW:0] trp;
    fefp_tx_st_t tst;
    logic [3:0] tcnt;
    logic col_pend;
    logic nib_hi;
    logic [LW-1:0] tsent;
    logic [4:0] tsym;
    fefp_rx_st_t rst;
    logic [3:0] rlo;
    logic rhi;
    logic [31:0] crc;
    logic [11:0] rlen;
    logic mcast;
    logic mc_rej;
    fefp_rxstat_t rstat;
    logic [AW:0] rwp;
    logic [AW:0] rrp;
    logic rflush;
    logic [4:0] rs1;
    logic [4:0] rs2;
  } fefp_st_t;

  // ------------------------------------------------------------------
  // Line coding helpers
  // ------------------------------------------------------------------
  function automatic logic [4:0] enc(input logic [3:0] nib);
    case (nib)
      4'h0: enc = 5'h1e;
      4'h1: enc = 5'h09;
      4'h2: enc = 5'h14;
      4'h3: enc = 5'h15;
      4'h4: enc = 5'h0a;
      4'h5: enc = 5'h0b;
      4'h6: enc = 5'h0e;
      4'h7: enc = 5'h0f;
      4'h8: enc = 5'h12;
      4'h9: enc = 5'h13;
      4'ha: enc = 5'h16;
      4'hb: enc = 5'h17;
      4'hc: enc = 5'h1a;
      4'hd: enc = 5'h1b;
      4'he: enc = 5'h1c;
      default: enc = 5'h1d;
    endcase
  endfunction : enc

  // Returns {valid, nibble}; anything outside the data set is invalid
  function automatic logic [4:0] dec(input logic [4:0] sym);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc(4'(i)) == sym) begin
        r = {1'b1, 4'(i)};
      end
    end
    dec = r;
  endfunction : dec

  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] b);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      if (x[0] ^ b[i]) begin
        x = (x >> 1) ^ `FEFP_CRC_POLY;
      end else begin
        x = x >> 1;
      end
    end
    crc8 = x;
  endfunction : crc8

  fefp_st_t s;
  fefp_st_t n;
  logic [7:0] tx_mem [2**AW];
  logic [7:0] rx_mem [2**AW];
  logic tx_we;
  logic rx_we;
  logic [7:0] rx_wd;
  logic [AW:0] tcount;
  logic [AW:0] rcount;
  logic [4:0] rsym;
  logic [7:0] tbyte;
  logic colli;
  logic tx_busy;

  assign tcount = s.twp - s.trp;
  assign rcount = s.rwp - s.rrp;
  assign tbyte = tx_mem[s.trp[AW-1:0]];
  assign rsym = s.ctrl.int_loop ? s.tsym : s.rs2;
  assign tx_busy = (s.tst != TX_IDLE) && (s.tst != TX_WAIT);
  // half duplex collision sense
  // Loopbacks see their own frame, so they never count as a collision
  assign colli = tx_busy && !s.ctrl.full_dup && !s.ctrl.int_loop &&
                 !s.ctrl.ext_loop && (s.rs2 != `FEFP_SYM_I);

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr & psel & penable;
  assign irq = |(s.ist & s.imask);
  assign txm_req = s.ld_act && !tcount[AW];
  assign txm_addr = s.ld_addr;
  assign rxm_req = (rcount != '0) && ((rcount >= rx_thresh) || s.rflush);
  assign rxm_data = rx_mem[s.rrp[AW-1:0]];
  // cable isolated; external loopback drives the line as normal
  assign line_tx_sym = s.ctrl.int_loop ? `FEFP_SYM_I : s.tsym;
  assign line_tx_en = !s.ctrl.int_loop && (s.tsym != `FEFP_SYM_I);

  always_comb begin
    logic [`FEFP_EV_W-1:0] ev;
    logic [4:0] dv;
    logic [7:0] rb;
    logic [31:0] c2;
    logic fin;
    logic ferr;
    logic fise;
    ev = '0;
    dv = dec(rsym);
    rb = '0;
    c2 = '0;
    fin = 1'b0;
    ferr = 1'b0;
    fise = 1'b0;
    n = s;
    tx_we = 1'b0;
    rx_we = 1'b0;
    rx_wd = '0;
    n.rs1 = line_rx_sym;
    n.rs2 = s.rs1;

    // ----------------------------------------------------------------
    // APB register file
    // ----------------------------------------------------------------
    if (psel && !penable) begin
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (paddr == `FEFP_CTRL) begin
        n.prdata = 32'(s.ctrl);
      end else if (paddr == `FEFP_TXADDR) begin
        n.prdata = s.tx_addr;
      end else if (paddr == `FEFP_TXLEN) begin
        n.prdata = 32'(s.tx_len);
      end else if (paddr == `FEFP_RXSTAT) begin
        n.prdata = 32'(s.rstat);
      end else if (paddr == `FEFP_HASH0) begin
        n.prdata = s.hash[31:0];
      end else if (paddr == `FEFP_HASH1) begin
        n.prdata = s.hash[63:32];
      end else if (paddr == `FEFP_ISTAT) begin
        n.prdata = 32'(s.ist);
      end else if (paddr == `FEFP_IMASK) begin
        n.prdata = 32'(s.imask);
      end else if (paddr == `FEFP_STATE) begin
        n.prdata = 32'({s.tst, s.rst});
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (psel && penable && pwrite) begin
      if (paddr == `FEFP_CTRL) begin
        n.ctrl = fefp_ctrl_t'(pwdata[3:0]);
        // host has stored the whole packet before this command
        if (pwdata[`FEFP_CTRL_GO] && s.tst == TX_IDLE && !s.ld_act &&
            s.tx_len != '0) begin
          n.ld_act = 1'b1;
          n.ld_done = 1'b0;
          n.ld_addr = s.tx_addr;
          n.ld_cnt = '0;
          n.twp = '0;
          n.trp = '0;
          n.tsent = '0;
          n.col_pend = 1'b0;
          n.tst = TX_WAIT;
        end
      end else if (paddr == `FEFP_TXADDR) begin
        n.tx_addr = pwdata;
      end else if (paddr == `FEFP_TXLEN) begin
        n.tx_len = pwdata[LW-1:0];
      end else if (paddr == `FEFP_HASH0) begin
        n.hash[31:0] = pwdata;
      end else if (paddr == `FEFP_HASH1) begin
        n.hash[63:32] = pwdata;
      end else if (paddr == `FEFP_ISTAT) begin
        n.ist = s.ist & ~pwdata[`FEFP_EV_W-1:0];
      end else if (paddr == `FEFP_IMASK) begin
        n.imask = pwdata[`FEFP_EV_W-1:0];
      end
    end

    // ----------------------------------------------------------------
    // Transmit fetch and line framing
    // ----------------------------------------------------------------
    // copy packet into transmit FIFO
    if (txm_req && txm_ack) begin
      tx_we = 1'b1;
      n.twp = (AW+1)'(s.twp + 1'b1);
      n.ld_addr = s.ld_addr + 32'h1;
      n.ld_cnt = LW'(s.ld_cnt + 1'b1);
      if (s.ld_cnt == LW'(s.tx_len - 1'b1)) begin
        n.ld_act = 1'b0;
        n.ld_done = 1'b1;
      end
    end
    case (s.tst)
      TX_IDLE: begin
        n.tsym = `FEFP_SYM_I;
      end
      TX_WAIT: begin
        if (s.ld_done || tcount >= tx_thresh) begin
          n.tst = TX_J;
        end
      end
      TX_J: begin
        n.tsym = `FEFP_SYM_J;
        n.tst = TX_K;
        n.col_pend = s.col_pend | colli;
      end
      TX_K: begin
        n.tsym = `FEFP_SYM_K;
        n.tst = TX_PRE;
        n.tcnt = '0;
        n.col_pend = s.col_pend | colli;
      end
      TX_PRE: begin
        n.tsym = enc((s.tcnt == `FEFP_PRE_LAST) ? `FEFP_NIB_SFD :
                     `FEFP_NIB_PRE);
        n.tcnt = 4'(s.tcnt + 1'b1);
        n.col_pend = s.col_pend | colli;
        if (s.tcnt == `FEFP_PRE_LAST) begin
          n.tcnt = '0;
          n.nib_hi = 1'b0;
          n.tst = TX_DATA;
          // jam only after the full preamble
          if (s.col_pend || colli) begin
            n.tst = TX_JAM;
            ev[`FEFP_EV_COL] = 1'b1;
          end
        end
      end
      TX_DATA: begin
        n.tsym = enc(s.nib_hi ? tbyte[7:4] : tbyte[3:0]);
        n.nib_hi = !s.nib_hi;
        if (s.nib_hi) begin
          n.trp = (AW+1)'(s.trp + 1'b1);
          n.tsent = LW'(s.tsent + 1'b1);
          // TR right after the last byte
          if (s.tsent == LW'(s.tx_len - 1'b1)) begin
            n.tst = TX_T;
          end
        end
        if (tcount == '0) begin
          // Host fell behind the threshold start; frame is cut short
          n.tsym = `FEFP_SYM_I;
          n.tst = TX_IDLE;
          n.ld_act = 1'b0;
          ev[`FEFP_EV_TXERR] = 1'b1;
        end
      end
      TX_T: begin
        n.tsym = `FEFP_SYM_T;
        n.tst = TX_R;
      end
      TX_R: begin
        n.tsym = `FEFP_SYM_R;
        n.tst = TX_IDLE;
        ev[`FEFP_EV_TXDONE] = 1'b1;
      end
      default: begin
        n.tsym = enc(`FEFP_NIB_PRE);
        n.tcnt = 4'(s.tcnt + 1'b1);
        if (s.tcnt == `FEFP_JAM_LAST) begin
          n.tst = TX_IDLE;
        end
      end
    endcase
    // collision after the preamble jams at once
    if (colli && (s.tst == TX_DATA || s.tst == TX_T || s.tst == TX_R)) begin
      n.tsym = enc(`FEFP_NIB_PRE);
      n.tcnt = 4'h1;
      n.tst = TX_JAM;
      ev[`FEFP_EV_COL] = 1'b1;
    end
    if (n.tst == TX_JAM) begin
      n.ld_act = 1'b0;
      n.trp = n.twp;
    end

    // ----------------------------------------------------------------
    // Receive decapsulation
    // ----------------------------------------------------------------
    case (s.rst)
      RX_IDLE: begin
        // start only on J; other line activity is ignored
        if (s.ctrl.rx_en && rsym == `FEFP_SYM_J) begin
          n.rst = RX_K;
        end
      end
      RX_K: begin
        // second half of the start pair
        n.rst = (rsym == `FEFP_SYM_K) ? RX_PRE : RX_DRAIN;
      end
      RX_PRE: begin
        if (!dv[4]) begin
          n.rst = RX_DRAIN;
        end else if (dv[3:0] == `FEFP_NIB_SFD) begin
          n.rst = RX_DATA;
          n.rhi = 1'b0;
          n.crc = `FEFP_CRC_INIT;
          n.rlen = '0;
          n.mcast = 1'b0;
          n.mc_rej = 1'b0;
        end
      end
      RX_DATA: begin
        if (rsym == `FEFP_SYM_T) begin
          n.rst = RX_R;
        end else if (rsym == `FEFP_SYM_I) begin
          fin = 1'b1;
          ferr = 1'b1;
        end else if (!dv[4]) begin
          fin = 1'b1;
          ferr = 1'b1;
          fise = 1'b1;
        end else if (!s.rhi) begin
          n.rlo = dv[3:0];
          n.rhi = 1'b1;
        end else begin
          rb = {dv[3:0], s.rlo};
          c2 = crc8(s.crc, rb);
          n.crc = c2;
          n.rhi = 1'b0;
          n.rlen = 12'(s.rlen + 1'b1);
          if (s.rlen == 12'h000) begin
            n.mcast = rb[0];
          end
          // hash lookup on the destination address
          if (s.rlen == 12'h005) begin
            n.mc_rej = s.mcast && !s.hash[c2[31:26]];
          end
          if (rcount[AW]) begin
            ev[`FEFP_EV_RXOVF] = 1'b1;
          end else begin
            rx_we = 1'b1;
            rx_wd = rb;
            n.rwp = (AW+1)'(s.rwp + 1'b1);
          end
        end
      end
      RX_R: begin
        // check FCS residue and closing R
        fin = 1'b1;
        ferr = (rsym != `FEFP_SYM_R) || (s.crc != `FEFP_CRC_RES);
      end
      default: begin
        if (rsym == `FEFP_SYM_I) begin
          n.rst = RX_IDLE;
        end
      end
    endcase
    if (fin) begin
      n.rstat = '{len: s.rlen, mc_rej: s.mc_rej, invalid_symbol_flag: fise,
                  crc_err: ferr, ok: !ferr};
      n.rst = fise ? RX_DRAIN : RX_IDLE;
      n.rflush = 1'b1;
      ev[`FEFP_EV_RXDONE] = 1'b1;
      ev[`FEFP_EV_RXERR] = ferr;
    end
    if (rxm_req && rxm_ack) begin
      n.rrp = (AW+1)'(s.rrp + 1'b1);
    end
    if (rcount == '0 && !fin) begin
      n.rflush = 1'b0;
    end

    // A new event wins over a clear in the same cycle
    n.ist = n.ist | ev;
  end

  // ------------------------------------------------------------------
  // State and FIFO storage
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tst <= TX_IDLE;
      s.rst <= RX_IDLE;
      s.tsym <= `FEFP_SYM_I;
      s.rs1 <= `FEFP_SYM_I;
      s.rs2 <= `FEFP_SYM_I;
      s.crc <= `FEFP_CRC_INIT;
    end else begin
      s <= n;
    end
  end

  // Storage is not reset; pointers alone define what is valid
  always_ff @(posedge pclk) begin
    if (tx_we) begin
      tx_mem[s.twp[AW-1:0]] <= txm_data;
    end
    if (rx_we) begin
      rx_mem[s.rwp[AW-1:0]] <= rx_wd;
    end
  end

endmodule : fefp_frame_path

//--- fefp_frame_path_monitor.sv
// Concurrent checks on the frame path ports
`timescale 1ns/10ps
`include "fefp_defines.svh"
module fefp_frame_path_monitor
  import fefp_pkg::*;
#(
  parameter int AW = 11,
  parameter int LW = 11
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Host memory side
  input wire logic txm_req,
  input wire logic [31:0] txm_addr,
  input wire logic txm_ack,
  input wire logic rxm_req,
  input wire logic [7:0] rxm_data,
  input wire logic rxm_ack,
  // Line side
  input wire logic [4:0] line_tx_sym,
  input wire logic line_tx_en
);
  // ----------------------------------------------------------------
  // Mode shadow
  // ----------------------------------------------------------------
  // Loop flag follows the control writes, as the bus cannot show it
  logic loop_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_r <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `FEFP_CTRL) begin
      loop_r <= pwdata[2];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  bus_ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  bad_addr_a: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (psel && penable && paddr <= 12'h020
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  loop_quiet_a: assert property (loop_r |-> !line_tx_en)
    else $error("line driven in internal loop");
  start_jk_a: assert property ($rose(line_tx_en) |->
    line_tx_sym == `FEFP_SYM_J ##1 line_tx_sym == `FEFP_SYM_K)
    else $error("frame not opened by start pair");
  pre_fill_a: assert property ($rose(line_tx_en) |->
    ##2 (line_tx_sym == 5'h0b) [*8]) else $error("preamble cut short");
  tr_pair_a: assert property (line_tx_en &&
    line_tx_sym == `FEFP_SYM_T |=> line_tx_sym == `FEFP_SYM_R)
    else $error("end pair broken");
  en_match_a: assert property (line_tx_en ==
    (line_tx_sym != `FEFP_SYM_I)) else $error("enable and symbol disagree");
  fetch_step_a: assert property (txm_req && txm_ack |=>
    txm_addr == $past(txm_addr) + 32'h1) else $error("fetch address stuck");
  rx_head_a: assert property (rxm_req && !rxm_ack |=>
    !rxm_req || $stable(rxm_data)) else $error("store byte moved unpopped");
endmodule : fefp_frame_path_monitor

//--- fefp_host_mem.sv
// Host memory model answering fetch and store requests of the frame path
`timescale 1ns/10ps
module fefp_host_mem (
  // Clock, reset, pacing
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] gap,
  // Transmit fetch
  input wire logic txm_req,
  input wire logic [31:0] txm_addr,
  output logic txm_ack,
  output logic [7:0] txm_data,
  // Receive store
  input wire logic rxm_req,
  input wire logic [7:0] rxm_data,
  output logic rxm_ack
);
  // whole packet is placed here by the bench before the start command
  logic [7:0] mem [256];
  logic [7:0] rxq [$];
  int n_fetch;
  logic [3:0] dly;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txm_ack <= 1'b0;
      rxm_ack <= 1'b0;
      txm_data <= 8'h00;
      dly <= 4'h0;
      n_fetch <= 0;
    end else begin
      // Data means nothing without the ack, so it is scrambled meanwhile
      txm_ack <= 1'b0;
      txm_data <= ~txm_data;
      rxm_ack <= rxm_req && !rxm_ack;
      if (txm_req && txm_ack) begin
        n_fetch <= n_fetch + 1;
      end
      if (rxm_req && rxm_ack) begin
        rxq.push_back(rxm_data);
      end
      if (dly != 4'h0) begin
        dly <= dly - 4'h1;
      end else if (txm_req && !txm_ack) begin
        txm_ack <= 1'b1;
        txm_data <= mem[txm_addr[7:0]];
        dly <= gap;
      end
    end
  end
endmodule : fefp_host_mem

//--- fefp_frame_path_tb.sv
// Testbench for the frame path with APB tasks and a host memory model
`timescale 1ns/10ps
`include "fefp_defines.svh"
module fefp_frame_path_tb;
  import fefp_pkg::*;
  localparam int AW = 4;
  localparam logic [79:0] ENC = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16,
    5'h13, 5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
  localparam logic [19:0] XP = {4'h1, 4'h9, 4'h6, 4'h2, 4'h1};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, txm_addr, r;
  logic [AW:0] tx_thresh, rx_thresh;
  logic txm_req, txm_ack, rxm_req, rxm_ack, line_tx_en;
  logic [7:0] txm_data, rxm_data;
  logic [4:0] line_tx_sym, line_rx_sym;
  logic [3:0] gap;
  logic [7:0] fr [8];
  logic [4:0] sq [$];
  logic [4:0] txq [$];
  int err_total, n_tests, b0, n;
  fefp_frame_path #(.AW(AW), .LW(11)) fefp_frame_path_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .tx_thresh, .rx_thresh, .txm_req, .txm_addr, .txm_ack, .txm_data,
    .rxm_req, .rxm_data, .rxm_ack, .line_tx_sym, .line_tx_en, .line_rx_sym);
  fefp_host_mem fefp_host_mem_i (.pclk, .presetn, .gap, .txm_req, .txm_addr,
    .txm_ack, .txm_data, .rxm_req, .rxm_data, .rxm_ack);
  always #50 pclk = ~pclk;
  always @(negedge pclk) begin
    if (line_tx_en === 1'b1) begin
      txq.push_back(line_tx_sym);
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rd
  task settle;
    repeat (3) @(posedge pclk);
  endtask : settle
  task wait_ev(input int b);
    int k;
    k = 0;
    r = 32'h0;
    while (r[b] !== 1'b1 && k < 400) begin
      apb(1'b0, `FEFP_ISTAT, 32'h0);
      k++;
    end
    chk(r[b], 1);
  endtask : wait_ev
  function automatic logic [4:0] enc(input logic [3:0] v);
    return ENC[v*5 +: 5];
  endfunction : enc
  task mkfr(input logic [7:0] b);
    logic [31:0] c;
    c = `FEFP_CRC_INIT;
    fr = '{b, 8'ha5, 8'h3c, 8'h7e, 8'h0, 8'h0, 8'h0, 8'h0};
    for (int i = 0; i < 4; i++) begin
      c = c ^ {24'h0, fr[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `FEFP_CRC_POLY : c >> 1;
    end
    for (int i = 0; i < 4; i++) fr[4+i] = ~c[8*i +: 8];
  endtask : mkfr
  task mkq(input int m);
    sq = {`FEFP_SYM_J, `FEFP_SYM_K};
    repeat (13) sq.push_back(enc(4'h5));
    sq.push_back(enc(4'hd));
    for (int i = 0; i < (m == 2 ? 2 : 8); i++) begin
      sq.push_back(enc(fr[i][3:0]));
      sq.push_back(enc(fr[i][7:4]));
    end
    if (m == 2) sq.push_back(5'h01);
    if (m == 0) sq = {sq, `FEFP_SYM_T, `FEFP_SYM_R};
  endtask : mkq
  task go(input logic [31:0] ctl);
    // host holds the whole packet before the start command
    for (int i = 0; i < 8; i++) fefp_host_mem_i.mem[16+i] = fr[i];
    apb(1'b1, `FEFP_TXADDR, 32'h10);
    apb(1'b1, `FEFP_TXLEN, 32'h8);
    apb(1'b1, `FEFP_CTRL, ctl);
    apb(1'b1, `FEFP_CTRL, ctl | 32'h10);
  endtask : go
  task tx_wait(input logic lvl);
    int k;
    k = 0;
    while (line_tx_en !== lvl && k < 900) begin
      k++;
      @(negedge pclk);
    end
    chk(line_tx_en, lvl);
  endtask : tx_wait
  task end_of_test;
    $display("Mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #3000000;
    err_total++;
    end_of_test;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    tx_thresh = 5'h1f;
    rx_thresh = 5'h04;
    line_rx_sym = `FEFP_SYM_I;
    gap = 4'h0;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FEFP_ISTAT, 32'hffffffff, 32'h0);
    apb(1'b1, `FEFP_HASH1, 32'h5a5a0f0f);
    rd(`FEFP_HASH1, 32'hffffffff, 32'h5a5a0f0f);
    apb(1'b0, 12'h040, 32'h0);
    chk({r[30:0], e}, 1);
    mkfr(8'h02);
    b0 = fefp_host_mem_i.rxq.size();
    go(32'h5);
    wait_ev(`FEFP_EV_RXDONE);
    rd(`FEFP_RXSTAT, 32'hf, 32'h1);
    n = 0;
    while (fefp_host_mem_i.rxq.size() < b0 + 8 && n < 300) begin
      n++;
      @(negedge pclk);
    end
    foreach (fr[i]) chk(fefp_host_mem_i.rxq[b0+i], fr[i]);
    chk(txq.size(), 0);
    apb(1'b1, `FEFP_IMASK, 32'h8);
    settle;
    chk(irq, 1);
    apb(1'b1, `FEFP_IMASK, 32'h0);
    settle;
    chk(irq, 0);
    apb(1'b1, `FEFP_IMASK, 32'h8);
    apb(1'b1, `FEFP_ISTAT, 32'h3f);
    settle;
    chk(irq, 0);
    rd(`FEFP_ISTAT, 32'h3f, 32'h0);
    // Slow host with both start levels, sent out on the line
    for (int i = 0; i < 2; i++) begin
      tx_thresh <= i ? 5'h1f : 5'h04;
      gap <= 4'h3;
      txq.delete();
      mkq(0);
      b0 = fefp_host_mem_i.n_fetch;
      go(32'h8);
      tx_wait(1'b1);
      n = fefp_host_mem_i.n_fetch - b0;
      chk(i ? n == 8 : n >= 4 && n < 8, 1);
      tx_wait(1'b0);
      settle;
      chk(txq.size(), sq.size());
      foreach (sq[k]) chk(txq[k], sq[k]);
    end
    // Line activity while sending: full duplex, then half duplex
    gap <= 4'h0;
    tx_thresh <= 5'h1f;
    for (int d = 1; d >= 0; d--) begin
      apb(1'b1, `FEFP_ISTAT, 32'h3f);
      txq.delete();
      go(d ? 32'h2 : 32'h0);
      tx_wait(1'b1);
      @(posedge pclk);
      line_rx_sym <= 5'h0b;
      repeat (3) @(posedge pclk);
      line_rx_sym <= `FEFP_SYM_I;
      tx_wait(1'b0);
      settle;
      rd(`FEFP_ISTAT, 32'h2, d ? 32'h0 : 32'h2);
      chk(txq.size(), d ? sq.size() : 24);
      for (int k = 0; k < 24; k++) chk(txq[k], d || k < 16 ? sq[k] : 5'h0b);
    end
    // Received frames: good, no end pair, bad symbol, group miss and hit
    apb(1'b1, `FEFP_CTRL, 32'h1);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, `FEFP_HASH0, c == 4 ? 32'hffffffff : 32'h0);
      apb(1'b1, `FEFP_HASH1, c == 4 ? 32'hffffffff : 32'h0);
      apb(1'b1, `FEFP_ISTAT, 32'h3f);
      mkfr(c < 3 ? 8'h02 : 8'h03);
      mkq(c < 3 ? c : 0);
      foreach (sq[i]) @(posedge pclk) line_rx_sym <= sq[i];
      @(posedge pclk);
      line_rx_sym <= `FEFP_SYM_I;
      wait_ev(`FEFP_EV_RXDONE);
      rd(`FEFP_RXSTAT, 32'hf, {28'h0, XP[4*c +: 4]});
      rd(`FEFP_ISTAT, 32'h10, (c == 1 || c == 2) ? 32'h10 : 32'h0);
    end
    end_of_test;
  end
endmodule : fefp_frame_path_tb
bind fefp_frame_path fefp_frame_path_monitor #(.AW(AW), .LW(LW))
  fefp_frame_path_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .txm_req, .txm_addr, .txm_ack,
  .rxm_req, .rxm_data, .rxm_ack, .line_tx_sym, .line_tx_en);
